// ---- bench/hbi_assertions.sv ----
//==============================================================
// Purpose: Bus timing checks for the host port.
// Assumes: Straps change only while reset is high.
// Notes:   Lengths are minimums, since a read may stretch.
`timescale 1ns/1ns
module hbi_checker (
  input wire logic        i_core_clk,
  input wire logic        i_srst,
  input wire logic        i_access_mode_strap,
  input wire logic        i_bus_style_strap_a,
  input wire logic        i_bus_style_strap_b,
  input wire logic        i_cs_n,
  input wire logic        i_rd_n,
  input wire logic        i_wr_n,
  input wire logic        i_address_strobe_n,
  input wire logic [16:0] i_host_address_lines,
  input wire logic        o_host_data_oe_n,
  input wire logic        o_wait_n,
  input wire logic        o_wait_oe_n,
  input wire logic        o_data_wr_stb,
  input wire logic        o_cmd_wr_stb,
  input wire logic        o_data_rd_stb
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  wire m68 = i_bus_style_strap_a & i_bus_style_strap_b;
  wire sel = !i_cs_n & (m68 ? !i_address_strobe_n & !i_rd_n : !i_rd_n | !i_wr_n);
  wire iw  = i_access_mode_strap & !i_wr_n;
  wire rs  = i_host_address_lines[0];
  wire stb = o_data_rd_stb | o_data_wr_stb | o_cmd_wr_stb;
  property p_go; $rose(sel) |=> !o_wait_oe_n && (o_wait_n == m68); endproperty
  a_go: assert property (p_go) else $error("wait not driven");
  property p_l80; $rose(sel) && !m68 |-> ##1 (!o_wait_n)[*5] ##[1:8] o_wait_n; endproperty
  a_l80: assert property (p_l80) else $error("bad cycle length");
  property p_l68; $rose(sel) && m68 |-> ##1 o_wait_n[*6] ##[1:8] !o_wait_n; endproperty
  a_l68: assert property (p_l68) else $error("bad cycle length");
  property p_late; $rose(sel) |-> o_host_data_oe_n[*3]; endproperty
  a_late: assert property (p_late) else $error("data driven early");
  property p_dw; $rose(sel) && iw && !rs |-> ##4 o_data_wr_stb && !o_cmd_wr_stb; endproperty
  a_dw: assert property (p_dw) else $error("data write missed");
  property p_cw; $rose(sel) && iw && rs |-> ##4 o_cmd_wr_stb && !o_data_wr_stb; endproperty
  a_cw: assert property (p_cw) else $error("command write missed");
  property p_qt; $rose(sel) && !(i_access_mode_strap && (iw || rs)) |-> ##1 (!stb)[*6]; endproperty
  a_qt: assert property (p_qt) else $error("stray strobe");
  property p_rel; $fell(sel) |=> o_host_data_oe_n && o_wait_n ##1 o_wait_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("pins not released");
  property p_rdv; m68 && i_wr_n && $fell(o_wait_n) |-> !o_host_data_oe_n && !o_wait_oe_n; endproperty
  a_rdv: assert property (p_rdv) else $error("read data late");
  cover property ($rose(sel) && m68 && iw);
  cover property ($rose(sel) && !i_access_mode_strap);
  cover property ($rose(o_data_rd_stb));
endmodule // hbi_checker
bind hbi_host_port hbi_checker u_chk (.i_core_clk, .i_srst, .i_access_mode_strap, .i_bus_style_strap_a,
  .i_bus_style_strap_b, .i_cs_n, .i_rd_n, .i_wr_n, .i_address_strobe_n, .i_host_address_lines,
  .o_host_data_oe_n, .o_wait_n, .o_wait_oe_n, .o_data_wr_stb, .o_cmd_wr_stb, .o_data_rd_stb);

// ---- bench/hbi_host_model.sv ----
//==============================================================
// Purpose: Host bus master driving 80 or 68 style cycles.
// Assumes: Drives on the falling clock edge.
// Notes:   Released address and data lines show inverted values, never the last ones.
`timescale 1ns/1ns
module hbi_host_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_m68,
  input  wire logic        i_wait_n,
  input  wire logic        i_wait_oe_n,
  input  wire logic        i_rd_oe_n,
  input  wire logic [15:0] i_rd_data,
  output logic             o_cs_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic             o_as_n,
  output logic [16:0]      o_addr,
  output logic [15:0]      o_data
);
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_as_n} = 4'hf;
    {o_addr, o_data} = 33'h0;
  end
  task automatic xfer(input logic wr, input logic [16:0] a, input logic [15:0] d,
                      output logic [15:0] q, output int n);
    @(negedge i_core_clk);
    {o_addr, o_data, o_cs_n, o_as_n} = {a, d, 1'b0, !i_m68};
    {o_rd_n, o_wr_n} = {i_m68 ? 1'b0 : wr, !wr};
    n = 0;
    // Strobes and address hold until wait reads high, or the acknowledge reads low.
    // The 68-style acknowledge ends a cycle by falling, the 80-style wait by rising.
    do @(posedge i_core_clk) n++; while (!(!i_wait_oe_n && (i_wait_n != i_m68)) && n < 40);
    q = i_rd_oe_n ? 16'hxxxx : i_rd_data;
    @(negedge i_core_clk);
    {o_cs_n, o_rd_n, o_wr_n, o_as_n} = 4'hf;
    {o_addr, o_data} = {~a, ~d};
    // Six idle clocks after a write cover the longer gap before a read.
    repeat (wr ? 5 : 1) @(negedge i_core_clk);
  endtask
endmodule // hbi_host_model

// ---- bench/testbench.sv ----
//==============================================================
// Purpose: Self-checking bench for the host port.
// Assumes: Straps move only while reset is high.
// Notes:   Each mode and bus style gets its own reset.
`timescale 1ns/1ns
module testbench;
  logic        i_core_clk, i_srst, i_access_mode_strap, i_bus_style_strap_a, i_bus_style_strap_b;
  logic        i_cs_n, i_rd_n, i_wr_n, i_address_strobe_n, o_host_data_oe_n, o_wait_n, o_wait_oe_n;
  logic        o_data_wr_stb, o_cmd_wr_stb, o_data_rd_stb;
  logic [16:0] i_host_address_lines;
  logic [15:0] i_host_data_lines, i_display_rd_data, o_host_data_lines, o_wr_data, q;
  int          n, miscompares, n_checks, cyc;
  int          n_dstb, n_cstb, n_rstb, s_d, s_c, s_r;
  hbi_host_port dut (.i_core_clk, .i_srst, .i_access_mode_strap, .i_bus_style_strap_a, .i_bus_style_strap_b,
    .i_cs_n, .i_rd_n, .i_wr_n, .i_address_strobe_n, .i_host_address_lines, .i_host_data_lines,
    .i_display_rd_data, .o_host_data_lines, .o_host_data_oe_n, .o_wait_n, .o_wait_oe_n, .o_data_wr_stb,
    .o_cmd_wr_stb, .o_data_rd_stb, .o_wr_data);
  hbi_host_model host (.i_core_clk, .i_m68(i_bus_style_strap_a & i_bus_style_strap_b), .i_wait_n(o_wait_n),
    .i_wait_oe_n(o_wait_oe_n), .i_rd_oe_n(o_host_data_oe_n), .i_rd_data(o_host_data_lines), .o_cs_n(i_cs_n),
    .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_as_n(i_address_strobe_n), .o_addr(i_host_address_lines),
    .o_data(i_host_data_lines));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Strobe pulses last one clock, so they are counted as they pass.
  always @(posedge i_core_clk) begin
    n_dstb += int'(o_data_wr_stb);
    n_cstb += int'(o_cmd_wr_stb);
    n_rstb += int'(o_data_rd_stb);
  end
  task automatic stb_chk(input logic [15:0] exp);
    chk(16'((n_dstb - s_d) * 256 + (n_cstb - s_c) * 16 + (n_rstb - s_r)), exp);
    {s_d, s_c, s_r} = {n_dstb, n_cstb, n_rstb};
  endtask
  task automatic complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rst(input logic m, a, b);
    @(negedge i_core_clk);
    {i_srst, i_access_mode_strap, i_bus_style_strap_a, i_bus_style_strap_b} = {1'b1, m, a, b};
    repeat (12) @(negedge i_core_clk);
    i_srst = 1'b0;
    chk(16'({o_host_data_oe_n, o_wait_n, o_wait_oe_n, o_data_wr_stb, o_cmd_wr_stb, o_data_rd_stb}), 16'h0038);
  endtask
  task automatic op(input logic wr, input logic [16:0] a, input logic [15:0] d, input int len);
    host.xfer(wr, a, d, q, n);
    chk({15'h0, n >= len && n < 40}, 16'h0001);
  endtask
  task automatic t_ind(input logic a, b);
    int k;
    k = a & b;
    rst(1'b1, a, b);
    op(1'b1, 17'h0a5a4, 16'h1234, 7 + k);
    stb_chk(16'h0100);
    chk(o_wr_data, 16'h1234);
    op(1'b1, 17'h00001, 16'h00c5, 7 + k);
    stb_chk(16'h0010);
    chk(o_wr_data, 16'h00c5);
    op(1'b0, 17'h00001, 16'h0000, 10 + k);
    chk(q, i_display_rd_data);
    stb_chk(16'h0001);
    op(1'b0, 17'h00000, 16'h0000, 6 + k);
    chk(q, 16'h0000);
    stb_chk(16'h0000);
    $display("indirect test %0d%0d done", a, b);
  endtask
  task automatic t_dir(input logic a, b);
    int k;
    k = a & b;
    rst(1'b0, a, b);
    op(1'b1, 17'h15553, 16'hc3a3, 7 + k);
    op(1'b1, 17'h0aaac, 16'h5c0c, 7 + k);
    op(1'b0, 17'h1fff3, 16'h0000, 10 + k);
    chk(q, 16'hc3a3);
    op(1'b0, 17'h0000c, 16'h0000, 6 + k);
    chk(q, 16'h5c0c);
    op(1'b0, 17'h12347, 16'h0000, 6 + k);
    chk(q, hbi_pkg::REG_RST_VAL);
    stb_chk(16'h0000);
    $display("direct test %0d%0d done", a, b);
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {i_srst, i_access_mode_strap, i_bus_style_strap_a, i_bus_style_strap_b} = 4'h8;
    i_display_rd_data = 16'h5a3c;
    t_ind(1'b0, 1'b0);
    t_ind(1'b1, 1'b1);
    t_dir(1'b0, 1'b1);
    t_dir(1'b1, 1'b1);
    complete_run();
  end
endmodule // testbench

// ---- rtl/hbi_host_port.sv ----
//==============================================================================
// Purpose: Host parallel bus port: decode, pacing by wait/acknowledge, regs.
// Assumes: Straps are static; bus inputs synchronous to the core clock.
// Notes:   Tri-state pins are split into value and active-low enable.
//==============================================================================
`timescale 1ns/1ns
module hbi_host_port (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_srst,
  input  wire logic                        i_access_mode_strap,
  input  wire logic                        i_bus_style_strap_a,
  input  wire logic                        i_bus_style_strap_b,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_rd_n,
  input  wire logic                        i_wr_n,
  input  wire logic                        i_address_strobe_n,
  input  wire logic [hbi_pkg::ADDR_W-1:0]  i_host_address_lines,
  input  wire logic [hbi_pkg::DATA_W-1:0]  i_host_data_lines,
  input  wire logic [hbi_pkg::DATA_W-1:0]  i_display_rd_data,
  output logic [hbi_pkg::DATA_W-1:0]       o_host_data_lines,
  output logic                             o_host_data_oe_n,
  output logic                             o_wait_n,
  output logic                             o_wait_oe_n,
  output logic                             o_data_wr_stb,
  output logic                             o_cmd_wr_stb,
  output logic                             o_data_rd_stb,
  output logic [hbi_pkg::DATA_W-1:0]       o_wr_data
);

  //============================================================================
  // Strap capture and strobe decode.
  //============================================================================
  logic                         style68_ff, nxt_style68;
  logic                         direct_ff,  nxt_direct;
  logic                         sel;
  logic                         is_rd;
  logic                         is_wr;

  always_comb begin
    // Straps are caught on every clock while reset is high and held once it is released.
    nxt_style68 = style68_ff;
    nxt_direct  = direct_ff;
    if (i_srst) begin
      nxt_style68 = i_bus_style_strap_a & i_bus_style_strap_b;
      nxt_direct  = ~i_access_mode_strap;
    end
  end

  always_ff @(posedge i_core_clk) begin
    style68_ff <= nxt_style68;
    direct_ff  <= nxt_direct;
  end

  always_comb begin
    if (style68_ff) begin
      // Read/write line plus enable strobe.
      sel   = ~i_cs_n & ~i_address_strobe_n & ~i_rd_n;
      is_rd = sel & i_wr_n;
      is_wr = sel & ~i_wr_n;
    end else begin
      sel   = ~i_cs_n & (~i_rd_n | ~i_wr_n);
      is_rd = sel & ~i_rd_n;
      is_wr = sel & ~i_wr_n & i_rd_n;
    end
  end

  //============================================================================
  // Cycle sequencer.
  //============================================================================
  hbi_pkg::hbi_state_e          state_ff, nxt_state;
  hbi_pkg::hbi_acc_e            acc_ff, nxt_acc, last_ff, nxt_last;
  logic [hbi_pkg::CNT_W-1:0]    cnt_ff, nxt_cnt;
  logic [hbi_pkg::CNT_W-1:0]    len;
  logic [hbi_pkg::DATA_W-1:0]   rdata_ff, nxt_rdata;
  logic                         drive_ff, nxt_drive;
  logic                         wait_ff, nxt_wait;
  logic                         waitoe_ff, nxt_waitoe;
  logic                         dstb_ff, nxt_dstb;
  logic                         cstb_ff, nxt_cstb;
  logic                         rstb_ff, nxt_rstb;
  logic [hbi_pkg::DATA_W-1:0]   wdata_ff, nxt_wdata;
  logic [hbi_pkg::REG_IDX_W-1:0] ridx;
  logic [hbi_pkg::DATA_W-1:0]   regs_ff [2**hbi_pkg::REG_IDX_W];
  logic [hbi_pkg::DATA_W-1:0]   nxt_regs [2**hbi_pkg::REG_IDX_W];

  assign ridx = i_host_address_lines[hbi_pkg::REG_IDX_W-1:0];

  always_comb begin
    // The pace of a cycle depends on what preceded it: a write makes a following
    // read longer so the core can absorb the write.
    if (style68_ff) begin
      len = (acc_ff == hbi_pkg::ACC_READ) ? hbi_pkg::M68_RD_LEN :
            (last_ff == hbi_pkg::ACC_WRITE && acc_ff == hbi_pkg::ACC_READ) ? hbi_pkg::M68_WR_LEN :
            hbi_pkg::M68_WW_LEN;
      if (acc_ff == hbi_pkg::ACC_READ && last_ff == hbi_pkg::ACC_WRITE)
        len = hbi_pkg::M68_WR_LEN;
    end else begin
      len = (acc_ff == hbi_pkg::ACC_READ) ? hbi_pkg::I80_RD_LEN : hbi_pkg::I80_WW_LEN;
      if (acc_ff == hbi_pkg::ACC_READ && last_ff == hbi_pkg::ACC_WRITE)
        len = hbi_pkg::I80_WR_LEN;
    end
  end

  always_comb begin
    nxt_state  = state_ff;
    nxt_acc    = acc_ff;
    nxt_last   = last_ff;
    nxt_cnt    = cnt_ff;
    nxt_rdata  = rdata_ff;
    nxt_drive  = drive_ff;
    nxt_wait   = wait_ff;
    nxt_waitoe = waitoe_ff;
    nxt_dstb   = 1'b0;
    nxt_cstb   = 1'b0;
    nxt_rstb   = 1'b0;
    nxt_wdata  = wdata_ff;
    nxt_regs   = regs_ff;
    case (state_ff)
      hbi_pkg::ST_IDLE: begin
        nxt_drive  = 1'b0;
        nxt_waitoe = 1'b1;
        nxt_wait   = 1'b1;
        if (sel) begin
          nxt_state  = hbi_pkg::ST_ACTIVE;
          nxt_acc    = is_rd ? hbi_pkg::ACC_READ : hbi_pkg::ACC_WRITE;
          nxt_cnt    = 4'h1;
          // The 80-style wait pin goes low while the cycle is busy. The 68-style
          // acknowledge is driven high at once and falls only when the cycle is done.
          nxt_wait   = style68_ff;
          nxt_waitoe = 1'b0;
        end
      end
      hbi_pkg::ST_ACTIVE: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (acc_ff == hbi_pkg::ACC_READ && cnt_ff == hbi_pkg::RD_DRIVE_CNT) begin
          nxt_drive = 1'b1;
          if (direct_ff) begin
            nxt_rdata = regs_ff[ridx];
          end else if (i_host_address_lines[0]) begin
            nxt_rdata = i_display_rd_data;
            nxt_rstb  = 1'b1;
          end else begin
            // This decode has no function: zeros go out and the core sees no fetch
            // strobe, so a stray read cannot disturb the display address.
            nxt_rdata = hbi_pkg::DATA_RST_VAL;
          end
        end
        if (acc_ff == hbi_pkg::ACC_WRITE && cnt_ff == (hbi_pkg::WR_SAMPLE_CNT - 4'h1)) begin
          nxt_wdata = i_host_data_lines;
          if (direct_ff)
            nxt_regs[ridx] = i_host_data_lines;
          else if (i_host_address_lines[0])
            nxt_cstb = 1'b1;
          else
            nxt_dstb = 1'b1;
        end
        if (cnt_ff >= len - 4'h1) begin
          nxt_state = hbi_pkg::ST_DONE;
          // Wait rises or the acknowledge falls here. Read data has stood since the
          // drive point, so it is valid well before the host takes it.
          nxt_wait  = ~style68_ff;
        end
      end
      hbi_pkg::ST_DONE: begin
        if (!sel) begin
          nxt_state  = hbi_pkg::ST_IDLE;
          nxt_last   = acc_ff;
          nxt_drive  = 1'b0;
          nxt_wait   = 1'b1;
          // The acknowledge stays driven high for one clock after the strobe rises
          // and is released from idle, so the line never floats from a low level.
          nxt_waitoe = ~style68_ff;
        end
      end
      default: nxt_state = hbi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_ff  <= hbi_pkg::ST_IDLE;
      acc_ff    <= hbi_pkg::ACC_NONE;
      last_ff   <= hbi_pkg::ACC_NONE;
      cnt_ff    <= '0;
      rdata_ff  <= hbi_pkg::DATA_RST_VAL;
      drive_ff  <= 1'b0;
      wait_ff   <= 1'b1;
      waitoe_ff <= 1'b1;
      dstb_ff   <= 1'b0;
      cstb_ff   <= 1'b0;
      rstb_ff   <= 1'b0;
      wdata_ff  <= hbi_pkg::DATA_RST_VAL;
      for (int i = 0; i < 2**hbi_pkg::REG_IDX_W; i++) begin
        regs_ff[i] <= hbi_pkg::REG_RST_VAL;
      end
    end else begin
      state_ff  <= nxt_state;
      acc_ff    <= nxt_acc;
      last_ff   <= nxt_last;
      cnt_ff    <= nxt_cnt;
      rdata_ff  <= nxt_rdata;
      drive_ff  <= nxt_drive;
      wait_ff   <= nxt_wait;
      waitoe_ff <= nxt_waitoe;
      dstb_ff   <= nxt_dstb;
      cstb_ff   <= nxt_cstb;
      rstb_ff   <= nxt_rstb;
      wdata_ff  <= nxt_wdata;
      regs_ff   <= nxt_regs;
    end
  end

  assign o_host_data_lines = rdata_ff;
  assign o_host_data_oe_n  = ~drive_ff;
  assign o_wait_n          = wait_ff;
  assign o_wait_oe_n       = waitoe_ff;
  assign o_data_wr_stb     = dstb_ff;
  assign o_cmd_wr_stb      = cstb_ff;
  assign o_data_rd_stb     = rstb_ff;
  assign o_wr_data         = wdata_ff;

endmodule // hbi_host_port

// ---- rtl/hbi_pkg.sv ----
//==============================================================================
// Purpose: Constants for the host parallel bus port of the LCD controller.
// Assumes: All bus pins are synchronous to i_core_clk.
// Notes:   Cycle counts are in core clock periods.
//==============================================================================
package hbi_pkg;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned ADDR_W       = 17;
  localparam int unsigned REG_IDX_W    = 4;
  localparam int unsigned CNT_W        = 4;
  // Write data is captured on the fourth rising edge of the cycle.
  localparam logic [3:0]  WR_SAMPLE_CNT = 4'h4;
  // Read data is not driven until three clocks after the strobe.
  localparam logic [3:0]  RD_DRIVE_CNT  = 4'h3;
  // Least cycle lengths, 80 style.
  localparam logic [3:0]  I80_RD_LEN    = 4'h6;
  localparam logic [3:0]  I80_WW_LEN    = 4'h7;
  localparam logic [3:0]  I80_WR_LEN    = 4'ha;
  // Least cycle lengths, 68 style.
  localparam logic [3:0]  M68_RD_LEN    = 4'h7;
  localparam logic [3:0]  M68_WW_LEN    = 4'h8;
  localparam logic [3:0]  M68_WR_LEN    = 4'hb;
  localparam logic [15:0] REG_RST_VAL   = 16'h0000;
  localparam logic [15:0] DATA_RST_VAL  = 16'h0000;
  typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_WRITE} hbi_acc_e;
  typedef enum {ST_IDLE, ST_ACTIVE, ST_DONE} hbi_state_e;
endpackage
